// ===== shared/health_rec_pkg.sv
// Package for the health attribute record builder: record layout,
// identifiers, flag words, fixed values and carrier structs.
// Assumes a single clock domain and byte-wide record readout.
package health_rec_pkg;

  localparam int REC_BYTES = 12;
  localparam int NUM_RECS = 5;
  localparam int NUM_CHIPS = 4;
  localparam int SPARE_W = 24;
  localparam int CNT_W = 32;
  localparam int ERASE_W = 48;
  localparam int FRAC_W = 32;

  // Record slots in readout order
  localparam logic [2:0] SLOT_SPARE = 3'h0;
  localparam logic [2:0] SLOT_ERASE = 3'h1;
  localparam logic [2:0] SLOT_ECC_TOTAL = 3'h2;
  localparam logic [2:0] SLOT_ECC_CORR = 3'h3;
  localparam logic [2:0] SLOT_CRC = 3'h4;

  // Byte positions inside a record
  localparam int POS_ID = 0;
  localparam int POS_FLAGS = 1;
  localparam int POS_VALUE = 3;
  localparam int POS_WORST = 4;
  localparam int POS_RAW = 5;
  localparam int POS_RSVD = 11;

  // Identifier bytes
  localparam logic [7:0] ID_SPARE = 8'hd5;
  localparam logic [7:0] ID_ERASE = 8'he5;
  localparam logic [7:0] ID_ECC_TOTAL = 8'hcb;
  localparam logic [7:0] ID_ECC_CORR = 8'hcc;
  localparam logic [7:0] ID_CRC = 8'hc7;

  // Flag words
  localparam logic [15:0] FLAGS_PREFAIL = 16'h0003;
  localparam logic [15:0] FLAGS_ADVISORY = 16'h0002;

  // Fixed value bytes and reset values
  localparam logic [7:0] VALUE_FIXED = 8'h64;
  localparam logic [7:0] LIFE_FULL = 8'h64;
  localparam logic [7:0] RSVD_BYTE = 8'h00;

  // Erase budget: target cycles per block times block count, split in percent steps
  localparam logic [FRAC_W-1:0] TARGET_ERASE_CYCLES = 32'h000186a0;
  localparam logic [FRAC_W-1:0] BLOCK_COUNT = 32'h00001000;
  localparam logic [63:0] ERASE_BUDGET = 64'(TARGET_ERASE_CYCLES) * 64'(BLOCK_COUNT);
  localparam logic [FRAC_W-1:0] ERASES_PER_PCT = FRAC_W'(ERASE_BUDGET / 64'h64);

  typedef logic [REC_BYTES-1:0][7:0] record_type;

  typedef struct packed {
    logic [SPARE_W-1:0] init_cnt;
    logic [SPARE_W-1:0] cur_cnt;
  } chip_spare_type;

  typedef struct packed {
    logic ecc_corr;
    logic ecc_uncorr;
    logic crc_err;
    logic block_erase;
  } event_type;

  typedef struct packed {
    logic en;
    logic [2:0] slot;
    logic [3:0] pos;
  } rd_req_type;

endpackage : health_rec_pkg

// ===== design/health_attribute_record_builder.sv
// Health attribute record builder: keeps live counters and serves
// 12-byte attribute records one byte per read request.
// Assumes event pulses and chip spare counts are synchronous to ref_clk.
`timescale 1ns/1ps

module health_attribute_record_builder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire health_rec_pkg::event_type events,
  input wire health_rec_pkg::chip_spare_type [health_rec_pkg::NUM_CHIPS-1:0] chip_spare,
  input wire logic [7:0] erase_threshold,
  input wire health_rec_pkg::rd_req_type rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] life_value,
  output logic threshold_exceeded
);

  typedef struct packed {
    logic [health_rec_pkg::CNT_W-1:0] ecc_total;
    logic [health_rec_pkg::CNT_W-1:0] ecc_corr;
    logic [health_rec_pkg::CNT_W-1:0] crc_cnt;
    logic [health_rec_pkg::ERASE_W-1:0] erase_total;
    logic [health_rec_pkg::FRAC_W-1:0] erase_frac;
    logic [7:0] life;
    logic [7:0] life_worst;
    health_rec_pkg::chip_spare_type worst_chip;
    logic [7:0] rd_data;
    logic rd_valid;
    logic thr;
  } state_type;

  state_type state_q;
  state_type state_d;

  // Saturating add of a small increment
  function automatic logic [health_rec_pkg::CNT_W-1:0] sat_add(
    input logic [health_rec_pkg::CNT_W-1:0] a,
    input logic [1:0] inc
  );
    logic [health_rec_pkg::CNT_W:0] sum;
    sum = {1'b0, a} + {{(health_rec_pkg::CNT_W-1){1'b0}}, inc};
    sat_add = sum[health_rec_pkg::CNT_W] ? {health_rec_pkg::CNT_W{1'b1}} : sum[health_rec_pkg::CNT_W-1:0];
  endfunction : sat_add

  // Packs one record, byte 0 first, multi-byte fields low byte first
  function automatic health_rec_pkg::record_type mk_rec(
    input logic [7:0] id,
    input logic [15:0] flags,
    input logic [7:0] val,
    input logic [7:0] worst,
    input logic [health_rec_pkg::ERASE_W-1:0] raw
  );
    mk_rec = {health_rec_pkg::RSVD_BYTE, raw, worst, val, flags, id};
  endfunction : mk_rec

  // Running minimum over chips by current spare count
  health_rec_pkg::chip_spare_type [health_rec_pkg::NUM_CHIPS-1:0] min_chain;

  assign min_chain[0] = chip_spare[0];

  genvar gi;
  generate
    for (gi = 1; gi < health_rec_pkg::NUM_CHIPS; gi++) begin : g_min
      assign min_chain[gi] = (chip_spare[gi].cur_cnt < min_chain[gi-1].cur_cnt) ?
                             chip_spare[gi] : min_chain[gi-1];
    end
  endgenerate

  // Live record images
  health_rec_pkg::record_type [health_rec_pkg::NUM_RECS-1:0] recs;

  always_comb begin
    recs[health_rec_pkg::SLOT_SPARE] = mk_rec(health_rec_pkg::ID_SPARE, health_rec_pkg::FLAGS_PREFAIL,
      health_rec_pkg::VALUE_FIXED, health_rec_pkg::VALUE_FIXED,
      {state_q.worst_chip.cur_cnt, state_q.worst_chip.init_cnt});
    recs[health_rec_pkg::SLOT_ERASE] = mk_rec(health_rec_pkg::ID_ERASE, health_rec_pkg::FLAGS_PREFAIL,
      state_q.life, state_q.life_worst,
      state_q.erase_total);
    recs[health_rec_pkg::SLOT_ECC_TOTAL] = mk_rec(health_rec_pkg::ID_ECC_TOTAL, health_rec_pkg::FLAGS_ADVISORY,
      health_rec_pkg::VALUE_FIXED, health_rec_pkg::VALUE_FIXED,
      {16'h0000, state_q.ecc_total});
    recs[health_rec_pkg::SLOT_ECC_CORR] = mk_rec(health_rec_pkg::ID_ECC_CORR, health_rec_pkg::FLAGS_ADVISORY,
      health_rec_pkg::VALUE_FIXED, health_rec_pkg::VALUE_FIXED,
      {16'h0000, state_q.ecc_corr});
    recs[health_rec_pkg::SLOT_CRC] = mk_rec(health_rec_pkg::ID_CRC, health_rec_pkg::FLAGS_ADVISORY,
      health_rec_pkg::VALUE_FIXED, health_rec_pkg::VALUE_FIXED,
      {16'h0000, state_q.crc_cnt});
  end

  always_comb begin
    logic [health_rec_pkg::ERASE_W:0] esum;
    logic [1:0] ecc_inc;
    logic step;
    esum = '0;
    ecc_inc = 2'h0;
    step = 1'b0;
    state_d = state_q;

    // Counters advance on every event while clk_en is high, regardless of host traffic
    ecc_inc = {1'b0, events.ecc_corr} + {1'b0, events.ecc_uncorr};
    state_d.ecc_total = sat_add(state_q.ecc_total, ecc_inc);
    state_d.ecc_corr = sat_add(state_q.ecc_corr, {1'b0, events.ecc_corr});
    state_d.crc_cnt = sat_add(state_q.crc_cnt, {1'b0, events.crc_err});

    if (events.block_erase) begin
      esum = {1'b0, state_q.erase_total} + {{health_rec_pkg::ERASE_W{1'b0}}, 1'b1};
      if (!esum[health_rec_pkg::ERASE_W]) begin
        state_d.erase_total = esum[health_rec_pkg::ERASE_W-1:0];
      end
      // One percent of life spent per erase budget step
      if (state_q.erase_frac >= health_rec_pkg::ERASES_PER_PCT - 32'h00000001) begin
        state_d.erase_frac = '0;
        step = 1'b1;
      end else begin
        state_d.erase_frac = state_q.erase_frac + 32'h00000001;
      end
    end

    if (step && state_q.life != 8'h00) begin
      state_d.life = state_q.life - 8'h01;
    end
    if (state_d.life < state_q.life_worst) begin
      state_d.life_worst = state_d.life;
    end

    state_d.worst_chip = min_chain[health_rec_pkg::NUM_CHIPS-1];

    // Only the erase usage value feeds the status check
    state_d.thr = (state_d.life < erase_threshold);

    state_d.rd_valid = rd_req.en;
    state_d.rd_data = 8'h00;
    if (rd_req.en && rd_req.slot < 3'(health_rec_pkg::NUM_RECS) &&
        rd_req.pos < 4'(health_rec_pkg::REC_BYTES)) begin
      state_d.rd_data = recs[rd_req.slot][rd_req.pos];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.life <= health_rec_pkg::LIFE_FULL;
      state_q.life_worst <= health_rec_pkg::LIFE_FULL;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.rd_data;
  assign rd_valid = state_q.rd_valid;
  assign life_value = state_q.life;
  assign threshold_exceeded = state_q.thr;

endmodule : health_attribute_record_builder

// ===== dv/health_rec_props.sv
// Port checker for the health attribute record builder.
// Bound to the design top from the bench top file; one clock domain.
`timescale 1ns/1ps
module health_rec_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire health_rec_pkg::rd_req_type rd_req,
  input wire logic [7:0] erase_threshold,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] life_value,
  input wire logic threshold_exceeded
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_byte(s, p, v);
    clk_en && rd_req.en && rd_req.slot == s && rd_req.pos == p |=> rd_data == v;
  endproperty
  a_read_answer: assert property (clk_en && rd_req.en |=> rd_valid) else $error("no answer");
  a_no_stray: assert property (clk_en && !rd_req.en |=> !rd_valid) else $error("stray valid");
  a_thresh_cmp: assert property ($past(rst_n) && $past(clk_en) |->
    threshold_exceeded == (life_value < $past(erase_threshold))) else $error("threshold");
  a_life_mono: assert property (life_value <= $past(life_value)) else $error("life rose");
  a_spare_id: assert property (p_byte(3'h0, 4'h0, 8'hd5)) else $error("spare id");
  a_erase_flag: assert property (p_byte(3'h1, 4'h1, 8'h03)) else $error("erase flags");
  a_total_id: assert property (p_byte(3'h2, 4'h0, 8'hcb)) else $error("total id");
  a_corr_id: assert property (p_byte(3'h3, 4'h0, 8'hcc)) else $error("corr id");
  a_crc_id: assert property (p_byte(3'h4, 4'h0, 8'hc7)) else $error("crc id");
  a_fixed_value: assert property (p_byte(3'h4, 4'h3, 8'h64)) else $error("value");
  a_pad_zero: assert property (p_byte(3'h2, 4'h9, 8'h00)) else $error("pad");
  c_read: cover property (rd_valid && rd_data == 8'hd5);
  c_thresh: cover property ($rose(threshold_exceeded));
  c_bad_slot: cover property (clk_en && rd_req.en && rd_req.slot > 3'h4);
endmodule : health_rec_props

// ===== dv/health_host_model.sv
// Host side model: issues record byte reads, one per cycle.
// Tasks are called from the bench just after a rising edge.
`timescale 1ns/1ps
module health_host_model (
  input wire logic ref_clk,
  output health_rec_pkg::rd_req_type rd_req
);
  initial rd_req = '0;
  task automatic issue(input logic [2:0] s, input logic [3:0] p);
    rd_req <= '{1'b1, s, p};
    @(posedge ref_clk);
  endtask : issue
  task automatic idle();
    rd_req <= '0;
    @(posedge ref_clk);
  endtask : idle
endmodule : health_host_model

// ===== dv/health_attribute_record_builder_bench.sv
// Self-checking bench for the health attribute record builder.
// Reads every record byte before and after random event traffic.
`timescale 1ns/1ps
module health_attribute_record_builder_bench;
  logic ref_clk, rst_n, clk_en, rd_valid, threshold_exceeded;
  logic [7:0] erase_threshold, rd_data, life_value;
  health_rec_pkg::event_type events;
  health_rec_pkg::chip_spare_type [health_rec_pkg::NUM_CHIPS-1:0] chip_spare;
  health_rec_pkg::rd_req_type rd_req;
  logic [7:0] exp_q[$];
  logic [3:0] ev;
  int n_errors = 0, checks = 0, n_corr = 0, n_tot = 0, n_crc = 0, n_erase = 0;
  integer seed = 32'hf619c220;
  health_host_model health_host_model_i (.ref_clk(ref_clk), .rd_req(rd_req));
  health_attribute_record_builder health_attribute_record_builder_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .events(events), .chip_spare(chip_spare), .erase_threshold(erase_threshold),
    .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid), .life_value(life_value),
    .threshold_exceeded(threshold_exceeded));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag
  function automatic logic [7:0] exp_byte(input int s, input int p);
    logic [47:0] raw;
    logic [7:0] ids [5];
    int w;
    ids = '{8'hd5, 8'he5, 8'hcb, 8'hcc, 8'hc7};
    w = 0;
    for (int c = 1; c < 4; c++) if (chip_spare[c].cur_cnt < chip_spare[w].cur_cnt) w = c;
    case (s)
      0: raw = {chip_spare[w].cur_cnt, chip_spare[w].init_cnt};
      1: raw = 48'(n_erase);
      2: raw = 48'(n_tot);
      3: raw = 48'(n_corr);
      default: raw = 48'(n_crc);
    endcase
    if (s > 4 || p > 10) return 8'h00;
    if (p == 0) return ids[s];
    if (p < 3) return p == 1 ? (s < 2 ? 8'h03 : 8'h02) : 8'h00;
    if (p < 5) return 8'h64;
    return raw[(p - 5) * 8 +: 8];
  endfunction : exp_byte
  // Every slot and position back to back, plus refused slot 5 and refused position 12
  task automatic sweep();
    for (int s = 0; s < 6; s++) for (int p = 0; p < 13; p++) begin
      exp_q.push_back(exp_byte(s, p));
      health_host_model_i.issue(3'(s), 4'(p));
    end
    health_host_model_i.idle();
    repeat (2) @(posedge ref_clk);
    cmp_flag(exp_q.size() == 0, 1'b1);
  endtask : sweep
  always @(negedge ref_clk) if (rd_valid === 1'b1) begin
    if (exp_q.size() == 0) cmp_flag(1'b1, 1'b0);
    else cmp_byte(rd_data, exp_q.pop_front());
  end
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    events = '0;
    erase_threshold = 8'h64;
    for (int c = 0; c < 4; c++) chip_spare[c] = {24'($random(seed)), 24'($random(seed))};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    sweep();
    for (int c = 0; c < 4; c++) chip_spare[c] <= {24'($random(seed)), 24'(c)};
    repeat (200) begin
      @(posedge ref_clk);
      ev = 4'($random(seed));
      events <= ev;
      n_corr += ev[3];
      n_tot += ev[3] + ev[2];
      n_crc += ev[1];
      n_erase += ev[0];
    end
    @(posedge ref_clk);
    events <= '0;
    sweep();
    cmp_flag(threshold_exceeded, 1'b0);
    erase_threshold <= 8'h65;
    repeat (2) @(posedge ref_clk);
    cmp_flag(threshold_exceeded, 1'b1);
    // Events while the clock enable is low are lost; counters must hold
    clk_en <= 1'b0;
    events <= 4'hf;
    repeat (3) @(posedge ref_clk);
    events <= '0;
    clk_en <= 1'b1;
    sweep();
    cmp_flag(threshold_exceeded, 1'b1);
    wrap_up();
  end
endmodule : health_attribute_record_builder_bench
bind health_attribute_record_builder health_rec_props health_rec_props_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .clk_en(clk_en), .rd_req(rd_req), .erase_threshold(erase_threshold), .rd_data(rd_data),
  .rd_valid(rd_valid), .life_value(life_value), .threshold_exceeded(threshold_exceeded));
